/* pin_config_pkg.sv */
package pin_config_pkg;

    // Clock rate and the input filter time.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FILTER_NS = 8000;
    // A least stable time, so the cycle count rounds up.
    localparam int unsigned FILTER_CYCLES = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FILTER_CNT_W = $clog2(FILTER_CYCLES + 1);

    // Register indices; the byte address is four times the index.
    localparam int unsigned REG_COUNT = 5;
    localparam logic [7:0] PIN3_CONFIG_IDX = 8'h33;
    localparam logic [7:0] PIN4_CONFIG_IDX = 8'h34;
    localparam logic [7:0] PIN5_CONFIG_IDX = 8'h35;
    localparam logic [7:0] PIN_DRIVE_IDX = 8'h40;
    localparam logic [7:0] PIN_LEVEL_IDX = 8'h41;
    localparam logic [7:0] REG_IDX [REG_COUNT] = '{PIN3_CONFIG_IDX, PIN4_CONFIG_IDX,
        PIN5_CONFIG_IDX, PIN_DRIVE_IDX, PIN_LEVEL_IDX};
    localparam logic [2:0] SEL_DRIVE = 3'h3;
    localparam logic [2:0] SEL_LEVEL = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // Configuration register layout and value after reset.
    localparam logic [7:0] CONFIG_RESET = 8'h0A;
    localparam int unsigned FUNC_LSB = 5;
    localparam int unsigned FUNC_W = 3;
    localparam int unsigned FILTER_BIT = 4;
    localparam int unsigned PULL_ON_BIT = 3;
    localparam int unsigned PULL_POL_BIT = 2;
    localparam int unsigned DRIVER_BIT = 1;
    localparam int unsigned OUTPUT_BIT = 0;

    // Function codes shared by all pins.
    localparam logic [2:0] FN_GPIO = 3'h0;
    localparam logic [2:0] FN_SLEEP_A = 3'h4;
    localparam logic [2:0] FN_SLEEP_B = 3'h5;
    localparam logic [2:0] FN_WAKE_A = 3'h6;
    localparam logic [2:0] FN_WAKE_B = 3'h7;
    // Function codes of single pins.
    localparam logic [2:0] FN3_I2C_DATA = 3'h1;
    localparam logic [2:0] FN3_SPI_OUT_A = 3'h2;
    localparam logic [2:0] FN3_SPI_OUT_B = 3'h3;
    localparam logic [2:0] FN4_ENABLE = 3'h1;
    localparam logic [2:0] FN4_WATCHDOG = 3'h2;
    localparam logic [2:0] FN4_MONITOR = 3'h3;
    localparam logic [2:0] FN5_SYNC_IN = 3'h1;
    localparam logic [2:0] FN5_SYNC_OUT = 3'h2;
    localparam logic [2:0] FN5_RESET_OUT = 3'h3;

    // Routed input bits and their idle values.
    localparam logic [8:0] ROUTE_RESET = 9'h061;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* pin_config_3_to_5.sv */
// The AXI4-Lite slave port was decided locally.
module pin_config_3_to_5
    import pin_config_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Nonvolatile defaults, loaded on a pulse.
    input wire logic nonvolatile_config_load,
    input wire logic [7:0] nonvolatile_config_pin3,
    input wire logic [7:0] nonvolatile_config_pin4,
    input wire logic [7:0] nonvolatile_config_pin5,
    // Pads; bit 0 is pin 3, bit 1 pin 4, bit 2 pin 5.
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    output logic [2:0] pull_up_on,
    output logic [2:0] pull_down_on,
    // Pin 3 functions.
    output logic second_i2c_data_line,
    input wire logic second_i2c_data_drive_low,
    input wire logic spi_serial_data_out,
    // Pin 4 functions.
    output logic device_enable_in,
    output logic watchdog_trigger_in,
    output logic first_converter_monitor_in,
    // Pin 5 functions.
    output logic switching_sync_clock_in,
    input wire logic switching_sync_clock_out,
    input wire logic processor_reset_out_n,
    // Functions shared by all pins.
    output logic sleep_request_a_n,
    output logic sleep_request_b_n,
    output logic wakeup_input_a,
    output logic wakeup_input_b
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write and read paths.
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = SEL_NONE;
        for (int k = 0; k < REG_COUNT; k++) begin
            if (a == (ADDR_W'(REG_IDX[k]) << 2)) begin
                reg_sel = 3'(k);
            end
        end
    endfunction

    logic [7:0] cfg_ff [3];
    logic [7:0] nxt_cfg [3];
    logic [2:0] drive_ff, nxt_drive;
    logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
    logic [2:0] wsel_ff, nxt_wsel;
    logic [7:0] wdata_ff, nxt_wdata;
    logic wlane_ff, nxt_wlane;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic do_write;
    logic [2:0] rsel;
    logic [2:0] sync1_ff, sync2_ff, filt_ff, nxt_filt, filter_active;
    logic [FILTER_CNT_W-1:0] cnt_ff [3];
    logic [FILTER_CNT_W-1:0] nxt_cnt [3];
    logic [2:0] fn [3];
    logic [2:0] out_ff, oe_ff, pu_ff, pd_ff, nxt_out, nxt_oe, nxt_pu, nxt_pd;
    logic [8:0] route_ff, nxt_route;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes; address and data are taken in either order.
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign rsel = reg_sel(s_axi_araddr);

    // Bus state and register contents; a nonvolatile load wins over a write.
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_wsel = wsel_ff;
        nxt_wdata = wdata_ff;
        nxt_wlane = wlane_ff;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_cfg = cfg_ff;
        nxt_drive = drive_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_hold = 1'b1;
            nxt_wsel = reg_sel(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_hold = 1'b1;
            nxt_wdata = s_axi_wdata[7:0];
            nxt_wlane = s_axi_wstrb[0];
        end
        if (do_write) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (wsel_ff == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wlane_ff && wsel_ff < SEL_DRIVE) begin
                nxt_cfg[wsel_ff[1:0]] = wdata_ff;
            end
            if (wlane_ff && wsel_ff == SEL_DRIVE) begin
                nxt_drive = wdata_ff[2:0];
            end
        end
        if (nonvolatile_config_load) begin
            nxt_cfg[0] = nonvolatile_config_pin3;
            nxt_cfg[1] = nonvolatile_config_pin4;
            nxt_cfg[2] = nonvolatile_config_pin5;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (rsel < SEL_DRIVE) begin
                nxt_rdata[7:0] = cfg_ff[rsel[1:0]];
            end else if (rsel == SEL_DRIVE) begin
                nxt_rdata[2:0] = drive_ff;
            end else if (rsel == SEL_LEVEL) begin
                nxt_rdata[2:0] = filt_ff;
            end else begin
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    // Bus and register flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            wsel_ff <= SEL_NONE;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            cfg_ff <= '{CONFIG_RESET, CONFIG_RESET, CONFIG_RESET};
            drive_ff <= 3'h0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            wsel_ff <= nxt_wsel;
            wdata_ff <= nxt_wdata;
            wlane_ff <= nxt_wlane;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            cfg_ff <= nxt_cfg;
            drive_ff <= nxt_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input filter: accept a change once it has held for the full filter time.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            fn[i] = cfg_ff[i][FUNC_LSB +: FUNC_W];
            filter_active[i] = cfg_ff[i][FILTER_BIT] && !cfg_ff[i][OUTPUT_BIT];
            nxt_filt[i] = filt_ff[i];
            nxt_cnt[i] = '0;
            if (!filter_active[i]) begin
                nxt_filt[i] = sync2_ff[i];
            end else if (sync2_ff[i] != filt_ff[i]) begin
                if (cnt_ff[i] == FILTER_CNT_W'(FILTER_CYCLES - 1)) begin
                    nxt_filt[i] = sync2_ff[i];
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + 1'b1;
                end
            end
        end
    end

    // Synchronizer and filter flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            filt_ff <= 3'h0;
            cnt_ff <= '{'0, '0, '0};
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            filt_ff <= nxt_filt;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad drive and pulls; registered so a write changes each pad once.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic drv;
            logic val;
            logic od;
            drv = 1'b0;
            val = 1'b0;
            od = cfg_ff[i][DRIVER_BIT];
            if (fn[i] == FN_GPIO) begin
                drv = cfg_ff[i][OUTPUT_BIT];
                val = drive_ff[i];
            end else if (i == 0 && fn[i] == FN3_I2C_DATA) begin
                drv = 1'b1;
                val = !second_i2c_data_drive_low;
                od = 1'b1;
            end else if (i == 0 && (fn[i] == FN3_SPI_OUT_A || fn[i] == FN3_SPI_OUT_B)) begin
                drv = 1'b1;
                val = spi_serial_data_out;
            end else if (i == 2 && fn[i] == FN5_SYNC_OUT) begin
                drv = 1'b1;
                val = switching_sync_clock_out;
            end else if (i == 2 && fn[i] == FN5_RESET_OUT) begin
                drv = 1'b1;
                val = processor_reset_out_n;
            end
            nxt_oe[i] = drv && (!od || !val);
            nxt_out[i] = !od && val;
            nxt_pu[i] = cfg_ff[i][PULL_ON_BIT] && cfg_ff[i][PULL_POL_BIT];
            nxt_pd[i] = cfg_ff[i][PULL_ON_BIT] && !cfg_ff[i][PULL_POL_BIT];
        end
    end

    // Pad flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= 3'h0;
            oe_ff <= 3'h0;
            pu_ff <= 3'h0;
            pd_ff <= 3'h7;
        end else begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            pu_ff <= nxt_pu;
            pd_ff <= nxt_pd;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
    assign pull_up_on = pu_ff;
    assign pull_down_on = pd_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Route filtered pin levels to the functions that selected them; the monitor input carries only whether pin 4 selected it.
    always_comb begin
        nxt_route = ROUTE_RESET;
        nxt_route[0] = (fn[0] == FN3_I2C_DATA) ? filt_ff[0] : 1'b1;
        nxt_route[1] = (fn[1] == FN4_ENABLE) && filt_ff[1];
        nxt_route[2] = (fn[1] == FN4_WATCHDOG) && filt_ff[1];
        nxt_route[3] = (fn[1] == FN4_MONITOR);
        nxt_route[4] = (fn[2] == FN5_SYNC_IN) && filt_ff[2];
        for (int i = 0; i < 3; i++) begin
            if (fn[i] == FN_SLEEP_A && !filt_ff[i]) nxt_route[5] = 1'b0;
            if (fn[i] == FN_SLEEP_B && !filt_ff[i]) nxt_route[6] = 1'b0;
            if (fn[i] == FN_WAKE_A && filt_ff[i]) nxt_route[7] = 1'b1;
            if (fn[i] == FN_WAKE_B && filt_ff[i]) nxt_route[8] = 1'b1;
        end
    end

    // Routed input flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_ff <= ROUTE_RESET;
        end else begin
            route_ff <= nxt_route;
        end
    end

    assign second_i2c_data_line = route_ff[0];
    assign device_enable_in = route_ff[1];
    assign watchdog_trigger_in = route_ff[2];
    assign first_converter_monitor_in = route_ff[3];
    assign switching_sync_clock_in = route_ff[4];
    assign sleep_request_a_n = route_ff[5];
    assign sleep_request_b_n = route_ff[6];
    assign wakeup_input_a = route_ff[7];
    assign wakeup_input_b = route_ff[8];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the registers, the pads, the filter and the routing.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    for (genvar g = 0; g < 3; g++) begin : g_chk
        cfg_reset_a: assert property ($past(!aresetn) |-> cfg_ff[g] == CONFIG_RESET)
            else $error("config register missed its reset value");
        pull_off_a: assert property ($past(!cfg_ff[g][PULL_ON_BIT]) |->
            !pull_up_on[g] && !pull_down_on[g]) else $error("pull active while off");
        pull_pick_a: assert property ($past(cfg_ff[g][PULL_ON_BIT]) |->
            pull_up_on[g] == $past(cfg_ff[g][PULL_POL_BIT]) && pull_down_on[g] != pull_up_on[g])
            else $error("wrong pull polarity");
        open_drain_a: assert property (pin_oe[g] && $past(cfg_ff[g][DRIVER_BIT]) |->
            !pin_out[g]) else $error("open drain drove high");
        gpio_dir_a: assert property ($past(fn[g] == FN_GPIO) |->
            pin_oe[g] == ($past(cfg_ff[g][OUTPUT_BIT]) &&
            (!$past(cfg_ff[g][DRIVER_BIT]) || !$past(drive_ff[g]))))
            else $error("gpio drive does not follow direction");
        filter_hold_a: assert property ($changed(filt_ff[g]) && $past(filter_active[g]) |->
            $past(cnt_ff[g]) == FILTER_CNT_W'(FILTER_CYCLES - 1))
            else $error("filtered level changed too early");
        sync_pass_a: assert property ($past(!filter_active[g]) |->
            filt_ff[g] == $past(sync2_ff[g])) else $error("unfiltered input not passed");
        wake_route_a: assert property ($past(fn[g] == FN_WAKE_A && filt_ff[g]) |->
            wakeup_input_a) else $error("wake input not routed");
    end

    spi_route_a: assert property ($past(fn[0] == FN3_SPI_OUT_A || fn[0] == FN3_SPI_OUT_B) &&
        !$past(cfg_ff[0][DRIVER_BIT]) |-> pin_oe[0] && pin_out[0] == $past(spi_serial_data_out))
        else $error("spi data not on pin");
    enable_route_a: assert property ($past(fn[1] == FN4_ENABLE) |->
        device_enable_in == $past(filt_ff[1]) && !watchdog_trigger_in)
        else $error("enable input not routed");
    monitor_pick_a: assert property (
        first_converter_monitor_in == $past(fn[1] == FN4_MONITOR))
        else $error("monitor source wrong");
    sync_in_a: assert property ($past(fn[2] == FN5_SYNC_IN) |->
        !pin_oe[2] && switching_sync_clock_in == $past(filt_ff[2]))
        else $error("sync clock input not routed");
    reset_out_a: assert property ($past(fn[2] == FN5_RESET_OUT) &&
        !$past(cfg_ff[2][DRIVER_BIT]) |-> pin_oe[2] && pin_out[2] == $past(processor_reset_out_n))
        else $error("reset output not on pin");
    write_apply_a: assert property (do_write && wlane_ff && wsel_ff < SEL_DRIVE &&
        !nonvolatile_config_load |=> cfg_ff[$past(wsel_ff[1:0])] == $past(wdata_ff))
        else $error("register write lost");

endmodule

/* pad_board_model.sv */
module pad_board_model (
    // Clock.
    input wire logic aclk,
    // Device pad controls.
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] pull_up_on,
    input wire logic [2:0] pull_down_on,
    // Board drivers.
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_lvl,
    // Resolved pad levels.
    output logic [2:0] pad_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] float_ff = 3'h0;
    // A floating pad flips every cycle, so no stale level can pass for a real one.
    always_ff @(posedge aclk) begin
        float_ff <= ~float_ff;
    end
    // The device driver wins, then the board, then the selected resistor.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i]) begin
                pad_lvl[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pad_lvl[i] = ext_lvl[i];
            end else if (pull_up_on[i]) begin
                pad_lvl[i] = 1'b1;
            end else if (pull_down_on[i]) begin
                pad_lvl[i] = 1'b0;
            end else begin
                pad_lvl[i] = float_ff[i];
            end
        end
    end
endmodule

/* multipurpose_pin_config_3_to_5_tb_top.sv */
module multipurpose_pin_config_3_to_5_tb_top import pin_config_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] dat;
        logic [2:0] drv;
        logic [2:0] een;
        logic [2:0] elv;
        logic [8:0] rt;
        logic [15:0] pad;
    } row_s;
    // Each row: register, value, drive, board enables, board levels, routes, pads.
    localparam row_s ROWS [18] = '{
        '{8'h33, 8'h00, 3'h0, 3'h7, 3'h1, 9'h061, 16'h0006},
        '{8'h33, 8'h0c, 3'h0, 3'h0, 3'h0, 9'h061, 16'h0016},
        '{8'h33, 8'h04, 3'h0, 3'h7, 3'h0, 9'h061, 16'h0006},
        '{8'h33, 8'h01, 3'h1, 3'h7, 3'h0, 9'h061, 16'h1106},
        '{8'h33, 8'h03, 3'h1, 3'h7, 3'h0, 9'h061, 16'h0006},
        '{8'h33, 8'h03, 3'h0, 3'h7, 3'h0, 9'h061, 16'h0106},
        '{8'h33, 8'h20, 3'h0, 3'h7, 3'h0, 9'h060, 16'h0006},
        '{8'h33, 8'h40, 3'h0, 3'h7, 3'h1, 9'h061, 16'h1106},
        '{8'h33, 8'h80, 3'h0, 3'h7, 3'h0, 9'h041, 16'h0006},
        '{8'h34, 8'ha0, 3'h0, 3'h7, 3'h0, 9'h001, 16'h0004},
        '{8'h35, 8'hc0, 3'h0, 3'h7, 3'h4, 9'h081, 16'h0000},
        '{8'h33, 8'he0, 3'h0, 3'h7, 3'h1, 9'h121, 16'h0000},
        '{8'h34, 8'h20, 3'h0, 3'h7, 3'h2, 9'h063, 16'h0000},
        '{8'h34, 8'h40, 3'h0, 3'h7, 3'h2, 9'h065, 16'h0000},
        '{8'h34, 8'h60, 3'h0, 3'h7, 3'h2, 9'h069, 16'h0000},
        '{8'h35, 8'h20, 3'h0, 3'h7, 3'h4, 9'h079, 16'h0000},
        '{8'h35, 8'h40, 3'h0, 3'h7, 3'h4, 9'h069, 16'h4400},
        '{8'h35, 8'h60, 3'h0, 3'h7, 3'h4, 9'h069, 16'h0400}
    };
    localparam logic [7:0] NV_VALS [3] = '{8'h2c, 8'h15, 8'he3};
    // Clock, reset and bus signals.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nonvolatile_config_load = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    // Pad and function signals.
    logic [7:0] nonvolatile_config_pin3 = 8'h00, nonvolatile_config_pin4 = 8'h00;
    logic [7:0] nonvolatile_config_pin5 = 8'h00;
    logic [2:0] ext_en = 3'h0, ext_lvl = 3'h0;
    logic [2:0] pad_lvl, pin_out, pin_oe, pull_up_on, pull_down_on;
    logic second_i2c_data_line, device_enable_in, watchdog_trigger_in;
    logic first_converter_monitor_in, switching_sync_clock_in;
    logic sleep_request_a_n, sleep_request_b_n, wakeup_input_a, wakeup_input_b;
    logic second_i2c_data_drive_low, spi_serial_data_out;
    logic switching_sync_clock_out, processor_reset_out_n;
    logic [8:0] routes;
    logic [15:0] pads;
    int n_fail = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Alternate output sources follow the board levels, so each row sets them too.
    assign spi_serial_data_out = ext_lvl[0];
    assign second_i2c_data_drive_low = ext_lvl[1];
    assign switching_sync_clock_out = ext_lvl[2];
    assign processor_reset_out_n = ~ext_lvl[2];
    // Observed routes and pad controls, packed for row comparison.
    assign routes = {wakeup_input_b, wakeup_input_a, sleep_request_b_n, sleep_request_a_n,
        switching_sync_clock_in, first_converter_monitor_in, watchdog_trigger_in,
        device_enable_in, second_i2c_data_line};
    assign pads = {1'b0, pin_out, 1'b0, pin_oe, 1'b0, pull_up_on, 1'b0, pull_down_on};
    // The clock toggles every half period.
    always #5 aclk = ~aclk;
    pad_board_model board (.aclk, .pin_out, .pin_oe, .pull_up_on, .pull_down_on,
        .ext_en, .ext_lvl, .pad_lvl);
    pin_config_3_to_5 #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .nonvolatile_config_load, .nonvolatile_config_pin3, .nonvolatile_config_pin4,
        .nonvolatile_config_pin5, .pin_in(pad_lvl), .pin_out, .pin_oe, .pull_up_on,
        .pull_down_on, .second_i2c_data_line, .second_i2c_data_drive_low,
        .spi_serial_data_out, .device_enable_in, .watchdog_trigger_in,
        .first_converter_monitor_in, .switching_sync_clock_in, .switching_sync_clock_out,
        .processor_reset_out_n, .sleep_request_a_n, .sleep_request_b_n, .wakeup_input_a,
        .wakeup_input_b);

    ////////////////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Byte address of a register index.
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // One write: address and data offered together, each dropped when taken.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (i == 100) begin
            n_fail++;
            final_report();
        end
    endtask

    // One read, data and response taken at the edge where rvalid is seen.
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (i == 100) begin
            n_fail++;
            final_report();
        end
    endtask

    // Checks register defaults and idle pads after a reset.
    task automatic check_defaults();
        for (int k = 0; k < 3; k++) begin
            axi_rd(ba(REG_IDX[k]), rd, resp);
            chk(rd, 32'h0000_000a);
        end
        chk(32'(pads), 32'h0000_0007);
        chk(32'(routes), 32'h0000_0061);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check_defaults();
        foreach (ROWS[k]) begin
            axi_wr(12'h100, 32'(ROWS[k].drv), resp);
            ext_en <= ROWS[k].een;
            ext_lvl <= ROWS[k].elv;
            axi_wr(ba(ROWS[k].idx), 32'(ROWS[k].dat), resp);
            chk(32'(resp), 32'(RESP_OKAY));
            repeat (8) @(posedge aclk);
            chk(32'(routes), 32'(ROWS[k].rt));
            chk(32'(pads), 32'(ROWS[k].pad));
            axi_rd(ba(ROWS[k].idx), rd, resp);
            chk(rd, 32'(ROWS[k].dat));
        end
        // A filtered input drops a short low pulse and accepts a long one.
        ext_lvl <= 3'h1;
        axi_wr(ba(PIN3_CONFIG_IDX), 32'h0000_0090, resp);
        repeat (820) @(posedge aclk);
        chk(32'(sleep_request_a_n), 32'h0000_0001);
        ext_lvl <= 3'h0;
        repeat (400) @(posedge aclk);
        ext_lvl <= 3'h1;
        repeat (20) @(posedge aclk);
        chk(32'(sleep_request_a_n), 32'h0000_0001);
        ext_lvl <= 3'h0;
        repeat (700) @(posedge aclk);
        chk(32'(sleep_request_a_n), 32'h0000_0001);
        repeat (120) @(posedge aclk);
        chk(32'(sleep_request_a_n), 32'h0000_0000);
        // Level register: pin 3 filtered low, pin 4 low, pin 5 driven high by reset out.
        axi_rd(12'h104, rd, resp);
        chk(rd, 32'h0000_0004);
        // An unmapped address is refused on both channels.
        axi_wr(12'h010, 32'h0000_00ff, resp);
        chk(32'(resp), 32'(RESP_SLVERR));
        axi_rd(12'h010, rd, resp);
        chk(rd, 32'h0000_0000);
        chk(32'(resp), 32'(RESP_SLVERR));
        // Nonvolatile defaults load on a pulse and read back.
        nonvolatile_config_pin3 <= NV_VALS[0];
        nonvolatile_config_pin4 <= NV_VALS[1];
        nonvolatile_config_pin5 <= NV_VALS[2];
        nonvolatile_config_load <= 1'b1;
        @(posedge aclk);
        nonvolatile_config_load <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            axi_rd(ba(REG_IDX[k]), rd, resp);
            chk(rd, 32'(NV_VALS[k]));
        end
        // A second reset in mid-run restores the defaults.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check_defaults();
        final_report();
    end
endmodule
